// [hdl/tcio_regs.svh]
// register offsets, field positions and reset values of the timer pin control block
`ifndef TCIO_REGS_SVH
`define TCIO_REGS_SVH

`define TCIO_OFF_IO_HIGH 8'h00
`define TCIO_OFF_IO_LOW 8'h04
`define TCIO_OFF_MODE 8'h08
`define TCIO_OFF_STATUS 8'h0C
`define TCIO_OFF_GR_A 8'h10
`define TCIO_OFF_GR_B 8'h14
`define TCIO_OFF_GR_C 8'h18
`define TCIO_OFF_GR_D 8'h1C

`define TCIO_FLD_HI_LSB 4
`define TCIO_FLD_LO_LSB 0
`define TCIO_MODE_BUF_A 0
`define TCIO_MODE_BUF_B 1

`define TCIO_RST_IO 8'h00
`define TCIO_RST_MODE 2'h0
`define TCIO_RST_GR 16'hFFFF

`define TCIO_ACT_NONE 2'h0
`define TCIO_ACT_LOW 2'h1
`define TCIO_ACT_HIGH 2'h2
`define TCIO_ACT_TOGGLE 2'h3
`define TCIO_CAP_RISE 2'h0
`define TCIO_CAP_FALL 2'h1

`endif

// [hdl/tcio_pkg.sv]
// types shared by the timer pin control block
package tcio_pkg;
  // one 4-bit function field: mode, initial level / don't care, action or edge
  typedef struct packed {
    logic capture;
    logic initLevel;
    logic [1:0] sel;
  } tcio_field_t;

  typedef enum logic [1:0] {
    TCIO_CH_A,
    TCIO_CH_B,
    TCIO_CH_C,
    TCIO_CH_D
  } tcio_ch_t;
endpackage

// [hdl/tcio_ch_if.sv]
// per-pin signals between the control core, the edge detector and the pin driver
`timescale 1ns/1ps
`default_nettype none
interface tcio_ch_if;
  import tcio_pkg::*;
  tcio_field_t field;
  logic active;
  logic initLoad;
  logic match;
  logic pinIn;
  logic rise;
  logic fall;
  logic pinOut;
  logic pinOe;

  modport ctrl (output field, output active, output initLoad, output match, output pinIn,
                input rise, input fall, input pinOut, input pinOe);
  modport detect (input pinIn, output rise, output fall);
  modport drive (input field, input active, input initLoad, input match,
                 output pinOut, output pinOe);
endinterface
`default_nettype wire

// [hdl/tcio_edge_detect.sv]
// edge detector for one timer pin
`timescale 1ns/1ps
`default_nettype none
module tcio_edge_detect
  import tcio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  tcio_ch_if.detect ch
);
  typedef struct packed {
    logic prev;
  } tcio_edge_state_t;

  tcio_edge_state_t state_q;
  tcio_edge_state_t state_d;

  always_comb begin
    state_d = state_q;
    state_d.prev = ch.pinIn;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // pin is synchronous to ref_clk, so no synchroniser stage
  assign ch.rise = ch.pinIn & ~state_q.prev;
  assign ch.fall = ~ch.pinIn & state_q.prev;
endmodule
`default_nettype wire

// [hdl/tcio_pin_drive.sv]
// compare-match pin driver for one timer pin
`timescale 1ns/1ps
`default_nettype none
`include "tcio_regs.svh"
module tcio_pin_drive
  import tcio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  tcio_ch_if.drive ch
);
  typedef struct packed {
    logic level;
    logic oe;
  } tcio_drive_state_t;

  tcio_drive_state_t state_q;
  tcio_drive_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (!ch.active || ch.field.capture) begin
      state_d.oe = 1'b0;
    end else if (ch.initLoad) begin
      state_d.level = ch.field.initLevel;
      state_d.oe = (ch.field.sel != `TCIO_ACT_NONE);
    end else begin
      state_d.oe = (ch.field.sel != `TCIO_ACT_NONE);
      if (ch.match) begin
        case (ch.field.sel)
          `TCIO_ACT_LOW: state_d.level = 1'b0;
          `TCIO_ACT_HIGH: state_d.level = 1'b1;
          `TCIO_ACT_TOGGLE: state_d.level = ~state_q.level;
          default: state_d.level = state_q.level;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign ch.pinOut = state_q.level;
  assign ch.pinOe = state_q.oe;
endmodule
`default_nettype wire

// [hdl/tcio_timer_io.sv]
// timer channel pin function control: compare outputs and input capture for four registers
`timescale 1ns/1ps
`default_nettype none
`include "tcio_regs.svh"
module tcio_timer_io
  import tcio_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [CNT_W-1:0] timerCount,
  input wire logic [3:0] timerPinIn,
  output logic [3:0] timerPinOut,
  output logic [3:0] timerPinOe,
  output logic [3:0] captureEvent
);
  localparam int NCH = 4;

  typedef struct packed {
    logic [7:0] ioHigh;
    logic [7:0] ioLow;
    logic [1:0] bufMode;
    logic [NCH-1:0][CNT_W-1:0] gr;
    logic [NCH-1:0] eqPrev;
    logic [NCH-1:0] flags;
    logic [NCH-1:0] initLoad;
    logic [NCH-1:0] capEvt;
    logic ack;
    logic [31:0] rdata;
  } tcio_top_state_t;

  tcio_top_state_t state_q;
  tcio_top_state_t state_d;

  tcio_ch_if chan [NCH] ();

  ////////////////////////////////////////////////////////////////////////////
  // field routing and per-pin decode

  tcio_field_t field [NCH];
  logic [NCH-1:0] active;
  logic [NCH-1:0] match;
  logic [NCH-1:0] capHit;
  logic [NCH-1:0] eqNow;
  logic [NCH-1:0] riseV;
  logic [NCH-1:0] fallV;
  logic [NCH-1:0] pinOutV;
  logic [NCH-1:0] pinOeV;

  always_comb begin
    field[TCIO_CH_A] = tcio_field_t'(state_q.ioHigh[`TCIO_FLD_LO_LSB +: 4]);
    field[TCIO_CH_B] = tcio_field_t'(state_q.ioHigh[`TCIO_FLD_HI_LSB +: 4]);
    field[TCIO_CH_C] = tcio_field_t'(state_q.ioLow[`TCIO_FLD_LO_LSB +: 4]);
    field[TCIO_CH_D] = tcio_field_t'(state_q.ioLow[`TCIO_FLD_HI_LSB +: 4]);
  end

  always_comb begin
    active = '1;
    // a buffered register neither captures nor compares
    active[TCIO_CH_C] = ~state_q.bufMode[`TCIO_MODE_BUF_A];
    active[TCIO_CH_D] = ~state_q.bufMode[`TCIO_MODE_BUF_B];
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      eqNow[i] = (timerCount == state_q.gr[i]);
      // only the first cycle of equality counts, so a stopped counter does not retoggle
      match[i] = active[i] & ~field[i].capture & eqNow[i] & ~state_q.eqPrev[i];
      case (field[i].sel)
        `TCIO_CAP_RISE: capHit[i] = riseV[i];
        `TCIO_CAP_FALL: capHit[i] = fallV[i];
        // the undefined 10 and 11 codes behave as both edges
        default: capHit[i] = riseV[i] | fallV[i];
      endcase
      capHit[i] = capHit[i] & active[i] & field[i].capture;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin edge detectors and compare drivers

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign chan[g].field = field[g];
    assign chan[g].active = active[g];
    assign chan[g].initLoad = state_q.initLoad[g];
    assign chan[g].match = match[g];
    assign chan[g].pinIn = timerPinIn[g];
    assign riseV[g] = chan[g].rise;
    assign fallV[g] = chan[g].fall;
    assign pinOutV[g] = chan[g].pinOut;
    assign pinOeV[g] = chan[g].pinOe;

    tcio_edge_detect u_edge (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .ch(chan[g])
    );

    // drives the pin level on match: low, high or toggle
    tcio_pin_drive u_drive (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .ch(chan[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave and register state

  logic busReq;
  logic wrEn;
  logic [31:0] rdMux;

  assign busReq = wb_cyc_i & wb_stb_i & ~state_q.ack;
  assign wrEn = busReq & wb_we_i;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (wb_adr_i)
      `TCIO_OFF_IO_HIGH: rdMux[7:0] = state_q.ioHigh;
      `TCIO_OFF_IO_LOW: rdMux[7:0] = state_q.ioLow;
      `TCIO_OFF_MODE: rdMux[1:0] = state_q.bufMode;
      `TCIO_OFF_STATUS: rdMux[NCH-1:0] = state_q.flags;
      `TCIO_OFF_GR_A: rdMux[CNT_W-1:0] = state_q.gr[TCIO_CH_A];
      `TCIO_OFF_GR_B: rdMux[CNT_W-1:0] = state_q.gr[TCIO_CH_B];
      `TCIO_OFF_GR_C: rdMux[CNT_W-1:0] = state_q.gr[TCIO_CH_C];
      `TCIO_OFF_GR_D: rdMux[CNT_W-1:0] = state_q.gr[TCIO_CH_D];
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    state_d.ack = busReq;
    state_d.initLoad = '0;
    state_d.eqPrev = eqNow;
    state_d.capEvt = capHit;
    if (busReq && !wb_we_i) begin
      state_d.rdata = rdMux;
    end

    if (wrEn && wb_sel_i[0]) begin
      case (wb_adr_i)
        `TCIO_OFF_IO_HIGH: begin
          state_d.ioHigh = wb_dat_i[7:0];
          // reload the initial pin level of both fields on every write with byte lane 0 enabled
          state_d.initLoad[TCIO_CH_A] = 1'b1;
          state_d.initLoad[TCIO_CH_B] = 1'b1;
        end
        `TCIO_OFF_IO_LOW: begin
          state_d.ioLow = wb_dat_i[7:0];
          state_d.initLoad[TCIO_CH_C] = 1'b1;
          state_d.initLoad[TCIO_CH_D] = 1'b1;
        end
        `TCIO_OFF_MODE: begin
          state_d.bufMode = wb_dat_i[1:0];
        end
        default: begin
        end
      endcase
    end

    // software writes to the general registers, byte lane by byte lane
    for (int i = 0; i < NCH; i++) begin
      if (wrEn && wb_adr_i == (`TCIO_OFF_GR_A + 8'(4 * i))) begin
        for (int b = 0; b < CNT_W / 8; b++) begin
          if (wb_sel_i[b]) begin
            state_d.gr[i][b*8 +: 8] = wb_dat_i[b*8 +: 8];
          end
        end
      end
      // a capture in the same cycle overrides the software write
      if (capHit[i]) begin
        state_d.gr[i] = timerCount;
      end
    end

    // status flags: write one to clear, a new event in the same cycle wins
    if (wrEn && wb_sel_i[0] && wb_adr_i == `TCIO_OFF_STATUS) begin
      state_d.flags = state_q.flags & ~wb_dat_i[NCH-1:0];
    end
    state_d.flags = state_d.flags | capHit | match;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q.ioHigh <= `TCIO_RST_IO;
      state_q.ioLow <= `TCIO_RST_IO;
      state_q.bufMode <= `TCIO_RST_MODE;
      state_q.gr <= {NCH{CNT_W'(`TCIO_RST_GR)}};
      state_q.eqPrev <= '0;
      state_q.flags <= '0;
      state_q.initLoad <= '0;
      state_q.capEvt <= '0;
      state_q.ack <= 1'b0;
      state_q.rdata <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o = state_q.ack;
  assign wb_dat_o = state_q.rdata;
  assign captureEvent = state_q.capEvt;
  assign timerPinOut = pinOutV;
  assign timerPinOe = pinOeV;
endmodule
`default_nettype wire

// [test/tcio_timer_io_assertions.sv]
// checker on the ports of the timer pin control block
`timescale 1ns/1ps
`default_nettype none
module tcio_timer_io_assertions #(
  parameter int CNT_W = 16
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [CNT_W-1:0] timerCount,
  input wire logic [3:0] timerPinIn,
  input wire logic [3:0] timerPinOut,
  input wire logic [3:0] timerPinOe,
  input wire logic [3:0] captureEvent
);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // control and mode writes are the only causes of an enable change
  wire ctrlWr = req & wb_we_i & wb_sel_i[0] & (wb_adr_i < 8'h0C);
  wire anyWr = req & wb_we_i;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_ack_one: assert property (req |=> wb_ack_o) else $error("no ack");
  chk_ack_idle: assert property (!(wb_cyc_i & wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  chk_dat_unmapped: assert property (req & !wb_we_i & wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_cap_pulse: assert property ((captureEvent & $past(captureEvent)) == 4'h0) else $error("long pulse");
  chk_cap_cause: assert property ((captureEvent & ~($past(timerPinIn) ^ $past(timerPinIn, 2))) == 4'h0)
    else $error("capture without edge");
  chk_cap_no_oe: assert property ((captureEvent & timerPinOe) == 4'h0) else $error("capture on driven pin");
  chk_oe_cause: assert property (timerPinOe != $past(timerPinOe) |-> $past(ctrlWr, 2) || $past(ctrlWr))
    else $error("enable changed without write");
  chk_pin_cause: assert property (timerPinOut != $past(timerPinOut) |->
    $past(anyWr, 2) || $past(anyWr) || $past(timerCount) != $past(timerCount, 2)) else $error("pin moved alone");
endmodule
bind tcio_timer_io tcio_timer_io_assertions #(.CNT_W(CNT_W)) chk (.ref_clk(ref_clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timerCount(timerCount),
  .timerPinIn(timerPinIn), .timerPinOut(timerPinOut), .timerPinOe(timerPinOe), .captureEvent(captureEvent));
`default_nettype wire

// [test/tcio_pin_model.sv]
// far side of the four timer pins
`timescale 1ns/1ps
`default_nettype none
module tcio_pin_model (
  input wire logic [3:0] extLevel,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  output logic [3:0] pinIn
);
  // the block wins where it drives; elsewhere the outside source sets the line
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule
`default_nettype wire

// [test/tcio_timer_io_tb_top.sv]
// self-checking bench for the timer pin control block
`timescale 1ns/1ps
`default_nettype none
module tcio_timer_io_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, clr = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, pOut, pOe, pIn, capEv, capSeen, ext = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [15:0] cnt = 16'h0000;
  int error_cnt = 0, n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  tcio_timer_io uut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timerCount(cnt),
    .timerPinIn(pIn), .timerPinOut(pOut), .timerPinOe(pOe), .captureEvent(capEv));
  tcio_pin_model pm (.extLevel(ext), .pinOut(pOut), .pinOe(pOe), .pinIn(pIn));
  always @(posedge ref_clk) capSeen <= clr ? 4'h0 : capSeen | capEv;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    chk(ack, 1'b1);
  endtask
  // each lane goes alone, low byte first
  task automatic setgr(input logic [7:0] a, input logic [15:0] v);
    wb(1'b1, a, 4'h1, {24'h0, v[7:0]});
    wb(1'b1, a, 4'h2, {16'h0, v[15:8], 8'h0});
  endtask
  task automatic hit;
    cnt <= 16'h0010;
    tick(2);
    cnt <= 16'h0000;
    tick(1);
  endtask
  // settle any edge left by a mode change before counting new captures
  task automatic pinStep(input logic [3:0] e, input logic [15:0] c);
    tick(4);
    cnt <= c;
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    ext <= e;
    tick(3);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a < 32; a += 4) begin
      wb(1'b0, a[7:0], 4'h3, 32'h0);
      chk(rd, a < 16 ? 32'h0 : 32'hFFFF);
    end
    wb(1'b1, 8'h20, 4'hF, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 4'hF, 32'h0);
    chk(rd, 32'h0);
    chk(pOe, 4'h0);
  endtask
  task automatic t_compare;
    logic [3:0] f, m;
    logic [7:0] v;
    for (int g = 16; g < 32; g += 4) setgr(g[7:0], 16'h0010);
    for (int s = 0; s < 2; s++) begin
      for (int a = 1; a < 4; a++) begin
        f = {2'b01, a[1:0]};
        v = s ? {f, 4'h0} : {4'h0, f};
        m = s ? 4'hA : 4'h5;
        wb(1'b1, 8'h00, 4'h1, {24'h0, v});
        wb(1'b1, 8'h04, 4'h1, {24'h0, v});
        tick(2);
        chk(pOe, m);
        chk(pOut & m, m);
        hit();
        chk(pOut & m, a == 2 ? m : 4'h0);
        hit();
        chk(pOut & m, a == 1 ? 4'h0 : m);
      end
    end
  endtask
  task automatic t_capture;
    logic [15:0] e [4] = '{16'h0100, 16'h0200, 16'h0200, 16'h0100};
    // the undefined capture code 11 is never written
    wb(1'b1, 8'h00, 4'h1, 32'h98);
    wb(1'b1, 8'h04, 4'h1, 32'hCA);
    pinStep(4'hF, 16'h0100);
    chk(capSeen, 4'hD);
    pinStep(4'h0, 16'h0200);
    chk(capSeen, 4'h6);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'h10 + 8'(4 * i), 4'h3, 32'h0);
      chk(rd[15:0], e[i]);
    end
    // every pin has matched or captured by now; write one clears, nothing new arrives meanwhile
    wb(1'b0, 8'h0C, 4'h1, 32'h0);
    chk(rd, 32'hF);
    wb(1'b1, 8'h0C, 4'h1, 32'hF);
    wb(1'b0, 8'h0C, 4'h1, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_buffer;
    wb(1'b1, 8'h08, 4'h1, 32'h3);
    pinStep(4'hF, 16'h0300);
    chk(capSeen, 4'h1);
    wb(1'b0, 8'h18, 4'h3, 32'h0);
    chk(rd[15:0], 16'h0200);
    wb(1'b1, 8'h04, 4'h1, 32'h66);
    tick(2);
    chk(pOe, 4'h0);
    wb(1'b1, 8'h08, 4'h1, 32'h0);
    tick(2);
    chk(pOe, 4'hC);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(3);
    nrst <= 1'b1;
    t_reset();
    t_compare();
    t_capture();
    t_buffer();
    give_verdict();
  end
  initial begin
    tick(20000);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
